// file: rtl/dps_consts.svh
/*
 * Register offsets, field positions, reset values and masks for the
 * device port state registers. Definitions only. Includers use the
 * bare name of this file.
 */
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH

// byte offsets on the apb side
`define DPS_OFF_FRAME       12'h000
`define DPS_OFF_STATE       12'h004
`define DPS_OFF_FADDR       12'h008
`define DPS_OFF_IRQ_EN      12'h010
`define DPS_OFF_IRQ_DIS     12'h014
`define DPS_OFF_IRQ_MASK    12'h018
`define DPS_OFF_IRQ_STAT    12'h01c
`define DPS_OFF_IRQ_CLR     12'h020
`define DPS_OFF_EP_RESET    12'h028
`define DPS_OFF_EP_CSR      12'h030
`define DPS_OFF_EP_FIFO     12'h050
`define DPS_OFF_TXVC        12'h074
`define DPS_EP_STRIDE       12'h004

// field positions
`define DPS_BIT_BAD         16
`define DPS_BIT_GOOD        17
`define DPS_BIT_ADDRESSED   0
`define DPS_BIT_CONFIGURED  1
`define DPS_BIT_FEN         8
`define DPS_BIT_SUSPEND     8
`define DPS_BIT_RESUME      9
`define DPS_BIT_SOF         11
`define DPS_BIT_FIXED_ONE   12
`define DPS_BIT_BUSRES      12
`define DPS_BIT_WAKEUP      13
`define DPS_BIT_BYTE_GOOD   4
`define DPS_BIT_BYTE_BAD    3

// reset values and writable-bit masks
`define DPS_FADDR_RESET     32'h0000_0100
`define DPS_MASK_RESET      14'h1200
`define DPS_MASK_WMASK      14'h2f0f
`define DPS_CLR_WMASK       14'h3b00

`endif

// file: rtl/dps_pkg.sv
/*
 * Types shared by the device port state registers.
 * Assumes the constants header is compiled alongside.
 */
package dps_pkg;

    // events from the packet engine, all synchronous to pclk
    typedef struct packed {
        logic        sof_pid;       // start-of-frame pid seen, one cycle
        logic        sof_eop;       // end of that sof packet, one cycle
        logic        sof_err;       // sof packet had an error, valid with sof_eop
        logic [10:0] sof_frame;     // frame count, valid with sof_eop
        logic        bus_reset_end; // end of bus reset, one cycle
        logic        suspend;       // suspend detected, one cycle
        logic        resume;        // resume detected, one cycle
        logic        wakeup;        // bus wakeup, one cycle
        logic [3:0]  ep_irq;        // endpoint interrupt levels
    } dps_link_t;

    // byte-wide view of the frame register
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dps_frame_bytes_t;

endpackage

// file: rtl/dps_port_regs.sv
/*
 * Register file of a full-speed usb device port: frame tracking,
 * device state, function address, interrupt mask and status, and the
 * decode of the per-endpoint control/status and fifo data registers.
 * Assumes an apb master on pclk, and a packet engine that presents its
 * events as one-cycle pulses synchronous to pclk.
 */
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "dps_consts.svh"

module dps_port_regs #(
    parameter int NUM_EP = 4
) (
    // clock, reset, freeze
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       clk_en,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic                            pready,
    output logic [31:0]                     prdata,
    // packet engine events
    input  wire dps_pkg::dps_link_t         link_in,
    // endpoint fifo access
    input  wire logic [31:0]                fifo_rdata,
    output logic                            fifo_wr,
    output logic                            fifo_rd,
    output logic [2:0]                      fifo_ep,
    output logic [31:0]                     fifo_wdata,
    // device state toward the packet engine
    output logic                            addressed_state_bit,
    output logic                            configured_state_bit,
    output logic [6:0]                      function_addr_value,
    output logic                            function_endpoints_on,
    output logic [13:0]                     irq_mask,
    output logic [13:0]                     irq_status,
    output logic [NUM_EP-1:0][31:0]         endpoint_ctrl_status,
    output logic [31:0]                     endpoint_reset,
    output logic [31:0]                     transceiver_control,
    // frame count and flags as words; the byte view carries only count bits 10:8 and both flags
    output logic [10:0]                     sof_frame_count,
    output logic                            sof_good_flag,
    output logic                            sof_bad_flag,
    output dps_pkg::dps_frame_bytes_t       frame_bytes
);
    import dps_pkg::*;

    // decoded access
    logic        rd_take;
    logic        wr_fire;
    logic        rd_fire;
    logic        csr_hit;
    logic        fifo_hit;
    logic [11:0] csr_rel;
    logic [11:0] fifo_rel;
    logic [2:0]  csr_idx;
    logic [2:0]  fifo_idx;
    logic [31:0] rd_mux;
    logic [13:0] set_vec;
    logic [13:0] next_status;

    // per-register write strobes
    logic        wr_state;
    logic        wr_faddr;
    logic        wr_irq_en;
    logic        wr_irq_dis;
    logic        wr_irq_clr;
    logic        wr_ep_reset;
    logic        wr_txvc;
    logic        wr_csr;

    // answer comes one cycle into the access phase
    assign rd_take = clk_en & psel & penable & ~pready;
    // writes and fifo pops happen only at the completing edge
    assign wr_fire = clk_en & psel & penable & pready & pwrite;
    assign rd_fire = clk_en & psel & penable & pready & ~pwrite;

    // one strobe per writable register; fixed offsets compare the full
    // address, so no alias of a register can write it
    assign wr_state    = wr_fire && (paddr == `DPS_OFF_STATE);
    assign wr_faddr    = wr_fire && (paddr == `DPS_OFF_FADDR);
    assign wr_irq_en   = wr_fire && (paddr == `DPS_OFF_IRQ_EN);
    assign wr_irq_dis  = wr_fire && (paddr == `DPS_OFF_IRQ_DIS);
    assign wr_irq_clr  = wr_fire && (paddr == `DPS_OFF_IRQ_CLR);
    assign wr_ep_reset = wr_fire && (paddr == `DPS_OFF_EP_RESET);
    assign wr_txvc     = wr_fire && (paddr == `DPS_OFF_TXVC);
    assign wr_csr      = wr_fire && csr_hit;

    // per-endpoint windows, word aligned only
    // a misaligned address falls through to the zero default
    assign csr_rel  = paddr - `DPS_OFF_EP_CSR;
    assign fifo_rel = paddr - `DPS_OFF_EP_FIFO;
    assign csr_idx  = csr_rel[4:2];
    assign fifo_idx = fifo_rel[4:2];
    assign csr_hit  = (paddr >= `DPS_OFF_EP_CSR)
                    && (csr_rel < 12'(NUM_EP * 4))
                    && (paddr[1:0] == 2'h0);
    assign fifo_hit = (paddr >= `DPS_OFF_EP_FIFO)
                    && (fifo_rel < 12'(NUM_EP * 4))
                    && (paddr[1:0] == 2'h0);

    // read data mux
    // reserved holes and write-only registers fall to zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `DPS_OFF_FRAME: begin
                rd_mux[10:0]          = sof_frame_count;
                rd_mux[`DPS_BIT_BAD]  = sof_bad_flag;
                rd_mux[`DPS_BIT_GOOD] = sof_good_flag;
            end
            `DPS_OFF_STATE: begin
                rd_mux[`DPS_BIT_ADDRESSED]  = addressed_state_bit;
                rd_mux[`DPS_BIT_CONFIGURED] = configured_state_bit;
            end
            `DPS_OFF_FADDR: begin
                rd_mux[6:0]          = function_addr_value;
                rd_mux[`DPS_BIT_FEN] = function_endpoints_on;
            end
            `DPS_OFF_IRQ_MASK: rd_mux[13:0] = irq_mask;
            `DPS_OFF_IRQ_STAT: rd_mux[13:0] = irq_status;
            `DPS_OFF_EP_RESET: rd_mux = endpoint_reset;
            `DPS_OFF_TXVC:     rd_mux = transceiver_control;
            // enable, disable and clear read back zero
            default: begin
                if (csr_hit) begin
                    rd_mux = endpoint_ctrl_status[csr_idx];
                end else if (fifo_hit) begin
                    rd_mux = fifo_rdata;
                end
            end
        endcase
    end

    // apb answer: one wait state so that prdata is a flop
    // prdata holds between reads; only a read's first access cycle loads it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            pready <= rd_take;
            if (rd_take && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // fifo strobes, one cycle each, at the completing edge
    // a stalled access phase never pops the fifo twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_wr    <= 1'b0;
            fifo_rd    <= 1'b0;
            fifo_ep    <= 3'h0;
            fifo_wdata <= 32'h0000_0000;
        end else if (clk_en) begin
            fifo_wr <= wr_fire & fifo_hit;
            fifo_rd <= rd_fire & fifo_hit;
            if ((wr_fire | rd_fire) && fifo_hit) begin
                fifo_ep <= fifo_idx;
            end
            if (wr_fire && fifo_hit) begin
                fifo_wdata <= pwdata;
            end
        end
    end

    // frame count refreshed only at the sof end of packet
    // the old count stays readable between a pid and its eop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sof_frame_count <= 11'h000;
        end else if (clk_en && link_in.sof_eop) begin
            sof_frame_count <= link_in.sof_frame;
        end
    end

    // frame quality flags; end of packet outranks a pid in the same cycle
    // a pid clears both, so between pid and eop neither flag is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sof_good_flag <= 1'b0;
            sof_bad_flag  <= 1'b0;
        end else if (clk_en) begin
            if (link_in.sof_eop) begin
                sof_bad_flag  <= link_in.sof_err;
                sof_good_flag <= ~link_in.sof_err;
            end else if (link_in.sof_pid) begin
                sof_bad_flag  <= 1'b0;
                sof_good_flag <= 1'b0;
            end
        end
    end

    // byte view of frame register for a narrow register interface
    // costs a cycle of lag but keeps the byte outputs on flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_bytes <= '0;
        end else if (clk_en) begin
            frame_bytes.high <= {3'h0, sof_good_flag, 1'b0, sof_frame_count[10:8]};
            frame_bytes.low  <= {4'h0, sof_bad_flag, 3'h0};
        end
    end

    // device state: address state leaves only through a reset
    // configured is read-write and also cleared by a bus reset end; software keeps the ordering
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addressed_state_bit  <= 1'b0;
            configured_state_bit <= 1'b0;
        end else if (clk_en) begin
            if (link_in.bus_reset_end) begin
                addressed_state_bit  <= 1'b0;
                configured_state_bit <= 1'b0;
            end else if (wr_state) begin
                if (pwdata[`DPS_BIT_ADDRESSED]) begin
                    addressed_state_bit <= 1'b1;
                end
                configured_state_bit <= pwdata[`DPS_BIT_CONFIGURED];
            end
        end
    end

    // function address and function enable
    // both fields load together, so one write sets address and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            function_addr_value   <= 7'h00;
            function_endpoints_on <= 1'b1;
        end else if (clk_en && wr_faddr) begin
            function_addr_value   <= pwdata[6:0];
            // gates data exchange in the packet engine
            function_endpoints_on <= pwdata[`DPS_BIT_FEN];
        end
    end

    // mask: set by enable, cleared by disable, restored by bus reset
    // bus reset outranks a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= `DPS_MASK_RESET;
        end else if (clk_en) begin
            if (link_in.bus_reset_end) begin
                irq_mask <= `DPS_MASK_RESET;
            end else if (wr_irq_en) begin
                irq_mask <= irq_mask | (pwdata[13:0] & `DPS_MASK_WMASK);
            end else if (wr_irq_dis) begin
                // bit 12 is outside the writable mask, so it stays one
                irq_mask <= irq_mask & ~(pwdata[13:0] & `DPS_MASK_WMASK);
            end
        end
    end

    // status events; a new event wins over a clear in the same cycle
    // so a clear racing an event never loses that event
    always_comb begin
        set_vec                     = 14'h0000;
        set_vec[`DPS_BIT_SUSPEND]   = link_in.suspend;
        set_vec[`DPS_BIT_RESUME]    = link_in.resume;
        set_vec[`DPS_BIT_SOF]       = link_in.sof_pid;
        set_vec[`DPS_BIT_BUSRES]    = link_in.bus_reset_end;
        set_vec[`DPS_BIT_WAKEUP]    = link_in.wakeup;
        next_status = irq_status;
        if (wr_irq_clr) begin
            next_status = irq_status & ~(pwdata[13:0] & `DPS_CLR_WMASK);
        end
        next_status       = next_status | set_vec;
        // endpoint bits follow the ep_irq levels from the packet engine, not the clear register
        next_status[3:0]  = link_in.ep_irq;
    end

    // status register; zeroed at reset though software may not rely on it
    // endpoint bits lag their levels by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 14'h0000;
        end else if (clk_en) begin
            irq_status <= next_status;
        end
    end

    // endpoint reset and transceiver control are plain storage here
    // their meaning belongs to the endpoint and transceiver logic outside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            endpoint_reset      <= 32'h0000_0000;
            transceiver_control <= 32'h0000_0000;
        end else if (clk_en) begin
            if (wr_ep_reset) begin
                endpoint_reset <= pwdata;
            end
            if (wr_txvc) begin
                transceiver_control <= pwdata;
            end
        end
    end

    // one csr per endpoint, each restored by the end of a bus reset
    // no field decode here, the word is stored whole
    for (genvar ep = 0; ep < NUM_EP; ep++) begin : g_ep_csr
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                endpoint_ctrl_status[ep] <= 32'h0000_0000;
            end else if (clk_en) begin
                if (link_in.bus_reset_end) begin
                    endpoint_ctrl_status[ep] <= 32'h0000_0000;
                end else if (wr_csr && csr_idx == 3'(ep)) begin
                    endpoint_ctrl_status[ep] <= pwdata;
                end
            end
        end
    end

endmodule

// file: dv/dps_port_regs_properties.sv
/*
 * Concurrent checks on the device port state registers.
 * Assumes it is bound into dps_port_regs and sees only its ports.
 */
`timescale 1ns/1ps
module dps_port_regs_properties (
    // clock and reset
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      clk_en,
    // apb side
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [11:0]               paddr,
    input wire logic                      pready,
    // link events and state
    input wire dps_pkg::dps_link_t        link_in,
    input wire logic                      fifo_wr,
    input wire logic [2:0]                fifo_ep,
    input wire logic                      addressed_state_bit,
    input wire logic [13:0]               irq_mask,
    input wire logic [13:0]               irq_status,
    input wire logic [10:0]               sof_frame_count,
    input wire logic                      sof_good_flag,
    input wire logic                      sof_bad_flag,
    input wire dps_pkg::dps_frame_bytes_t frame_bytes
);
    import dps_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // pid alone; with eop present the flags follow eop
    sequence s_pid;
        clk_en && link_in.sof_pid && !link_in.sof_eop;
    endsequence
    sequence s_eop;
        clk_en && link_in.sof_eop;
    endsequence
    // completing edge of a word written to an endpoint fifo
    sequence s_fifo_wr;
        clk_en && psel && penable && pwrite && pready && paddr[11:4] == 8'h05
            && paddr[1:0] == 2'b00;
    endsequence
    a_sof_status: assert property (s_pid |=> irq_status[11])
        else $error("sof status not raised by pid");
    a_frame_count: assert property (s_eop |=> sof_frame_count == $past(link_in.sof_frame))
        else $error("frame count not taken at eop");
    a_bad_flag: assert property (s_eop |=> sof_bad_flag == $past(link_in.sof_err))
        else $error("bad flag wrong after eop");
    a_good_flag: assert property (s_eop |=> sof_good_flag == !$past(link_in.sof_err))
        else $error("good flag wrong after eop");
    a_flag_clear: assert property (s_pid |=> !sof_good_flag && !sof_bad_flag)
        else $error("flags not cleared by pid");
    a_mask_fixed: assert property (irq_mask[12])
        else $error("fixed mask bit low");
    a_bus_reset: assert property (clk_en && link_in.bus_reset_end |=>
        irq_mask == 14'h1200 && !addressed_state_bit && irq_status[12])
        else $error("bus reset end did not restore state");
    a_fifo_strobe: assert property (s_fifo_wr |=>
        fifo_wr && fifo_ep == 3'(($past(paddr) - 12'h050) >> 2))
        else $error("fifo write strobe or endpoint wrong");
    a_byte_view: assert property (clk_en |=> frame_bytes.high[4] == $past(sof_good_flag)
        && frame_bytes.low[3] == $past(sof_bad_flag))
        else $error("byte view flags wrong");
endmodule

bind dps_port_regs dps_port_regs_properties chk_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .link_in(link_in), .fifo_wr(fifo_wr),
    .fifo_ep(fifo_ep), .addressed_state_bit(addressed_state_bit), .irq_mask(irq_mask),
    .irq_status(irq_status), .sof_frame_count(sof_frame_count),
    .sof_good_flag(sof_good_flag), .sof_bad_flag(sof_bad_flag), .frame_bytes(frame_bytes)
);

// file: dv/dps_host_model.sv
/*
 * Behavioural host side: start-of-frame packets, bus events, endpoint levels.
 * Assumes tasks are called right after a rising pclk edge.
 */
`timescale 1ns/1ps
module dps_host_model (
    // clock
    input wire logic         pclk,
    // events toward the port
    output dps_pkg::dps_link_t link
);
    import dps_pkg::*;
    logic [3:0] lv;
    initial begin
        lv = 4'h0;
        link = '0;
    end
    // one event cycle; frame fields then go invalid, not stale
    task automatic fire(input dps_link_t ev);
        dps_link_t idle;
        @(posedge pclk);
        ev.ep_irq = lv;
        link <= ev;
        @(posedge pclk);
        idle = '0;
        idle.sof_err = ~ev.sof_err;
        idle.sof_frame = ~ev.sof_frame;
        idle.ep_irq = lv;
        link <= idle;
    endtask
    // pid leads, eop follows after a prompt or slow gap
    task automatic sof(input logic [10:0] f, input logic e, input int gap);
        dps_link_t ev;
        ev = '0;
        ev.sof_pid = 1'b1;
        fire(ev);
        repeat (gap) @(posedge pclk);
        ev = '0;
        ev.sof_eop = 1'b1;
        ev.sof_err = e;
        ev.sof_frame = f;
        fire(ev);
    endtask
    // 0 suspend, 1 resume, 2 wakeup, 3 end of bus reset
    task automatic kick(input int k);
        dps_link_t ev;
        ev = '0;
        ev.suspend = (k == 0);
        ev.resume = (k == 1);
        ev.wakeup = (k == 2);
        ev.bus_reset_end = (k == 3);
        fire(ev);
    endtask
    task automatic levels(input logic [3:0] v);
        @(posedge pclk);
        lv = v;
        link.ep_irq <= v;
    endtask
endmodule

// file: dv/usb_device_port_state_regs_tb.sv
/*
 * Self-checking bench for dps_port_regs: apb master, read queue, host model.
 * Assumes the bound checker and dps_host_model are compiled alongside.
 */
`timescale 1ns/1ps
module usb_device_port_state_regs_tb;
    import dps_pkg::*;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, fifo_rdata, fifo_wdata;
    logic        fifo_wr, fifo_rd;
    logic [2:0]  fifo_ep;
    dps_link_t   link;
    logic [31:0] expq[$];
    logic [31:0] rs = 32'h2ffc70c4;
    int          fails = 0;
    int          tests_run = 0;
    localparam logic [13:0] WM = 14'h2f0f;
    logic [11:0] ra[12] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014,
                            12'h018, 12'h020, 12'h024, 12'h030, 12'h070, 12'h078};
    logic [11:0] rw[6] = '{12'h030, 12'h034, 12'h038, 12'h03c, 12'h028, 12'h074};

    dps_port_regs dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .link_in(link), .fifo_rdata(fifo_rdata), .fifo_wr(fifo_wr), .fifo_rd(fifo_rd),
        .fifo_ep(fifo_ep), .fifo_wdata(fifo_wdata), .addressed_state_bit(),
        .configured_state_bit(),
        .function_addr_value(), .function_endpoints_on(), .irq_mask(), .irq_status(),
        .endpoint_ctrl_status(), .endpoint_reset(), .transceiver_control(),
        .sof_frame_count(), .sof_good_flag(), .sof_bad_flag(), .frame_bytes()
    );
    dps_host_model host (.pclk(pclk), .link(link));

    always #5 pclk = ~pclk;

    function logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        xfer(1'b0, a, rnd());
    endtask
    // read data is judged at the edge that samples pready
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            chk("prdata", prdata, expq.size() > 0 ? expq.pop_front() : 32'hx);
        end
    end

    initial begin
        logic [31:0] r, q;
        logic [13:0] m;
        logic [10:0] f;
        {pclk, psel, penable, pwrite, paddr, pwdata, fifo_rdata} = '0;
        presetn = 1'b0;
        clk_en = 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, write-only and reserved places
        foreach (ra[i]) begin
            rd(ra[i], ra[i] == 12'h008 ? 32'h100 : ra[i] == 12'h018 ? 32'h1200 : 32'h0);
        end
        r = rnd();
        wr(12'h00c, r);
        wr(12'h000, r);
        rd(12'h00c, 32'h0);
        rd(12'h000, 32'h0);
        // address loaded before the state bits, reserved bits ignored
        wr(12'h008, (r & 32'hffff_fe00) | 32'h100 | 32'(r[6:0]));
        rd(12'h008, 32'h100 | 32'(r[6:0]));
        wr(12'h004, 32'h1);
        rd(12'h004, 32'h1);
        wr(12'h004, 32'h3);
        rd(12'h004, 32'h3);
        wr(12'h004, 32'h0);
        rd(12'h004, 32'h1);
        wr(12'h008, 32'(r[6:0]));
        rd(12'h008, 32'(r[6:0]));
        wr(12'h008, 32'h100);
        // mask built up one bit at a time
        wr(12'h014, 32'hffff_ffff);
        m = 14'h1000;
        rd(12'h018, 32'(m));
        for (int i = 0; i < 14; i++) begin
            wr(12'h010, 32'h1 << i);
            m = m | (WM & (14'h1 << i));
            rd(12'h018, 32'(m));
        end
        wr(12'h014, 32'h200);
        rd(12'h018, 32'h3d0f);
        // storage registers and endpoint fifo words
        foreach (rw[i]) begin
            r = rnd();
            wr(rw[i], r);
            rd(rw[i], r);
        end
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            wr(12'h050 + 12'(4 * i), r);
            @(posedge pclk);
            chk("fifo_wdata", fifo_wdata, r);
            chk("fifo_wr", 32'(fifo_wr), 32'h1);
            q = rnd();
            fifo_rdata <= q;
            rd(12'h050 + 12'(4 * i), q);
            @(posedge pclk);
            chk("fifo_rd", 32'(fifo_rd), 32'h1);
            chk("fifo_ep", 32'(fifo_ep), 32'(i));
        end
        // frames, clean then errored with a slow eop
        wr(12'h020, 32'h3b00);
        f = r[10:0];
        host.sof(f, 1'b0, 1);
        rd(12'h000, 32'h20000 | 32'(f));
        rd(12'h01c, 32'h800);
        host.sof(~f, 1'b1, 6);
        rd(12'h000, 32'h10000 | {21'h0, ~f});
        // frozen clock enable: a bus reset end pulse must be lost
        clk_en <= 1'b0;
        host.kick(3);
        clk_en <= 1'b1;
        rd(12'h018, 32'h3d0f);
        rd(12'h004, 32'h1);
        // bus events and endpoint levels, then clears
        for (int k = 0; k < 3; k++) begin
            host.kick(k);
        end
        host.levels(4'ha);
        wr(12'h020, 32'h800);
        rd(12'h01c, 32'h230a);
        wr(12'h020, 32'hffff_ffff);
        rd(12'h01c, 32'h000a);
        host.kick(3);
        rd(12'h018, 32'h1200);
        rd(12'h004, 32'h0);
        rd(12'h030, 32'h0);
        rd(12'h01c, 32'h100a);
        repeat (4) @(posedge pclk);
        conclude();
    end
endmodule
